// ---- shared/qlos_pkg.sv ----
// Constants shared by the quad latch output select logic
package qlos_pkg;

    // ********************************************************
    // Sizes
    // ********************************************************
    localparam int NUM_CH = 16;
    localparam int CODE_W = 2;
    localparam int CTRL_W = NUM_CH * CODE_W;
    localparam int NUM_ARR = 4;
    localparam int SR_W = NUM_ARR * CTRL_W;

    // ********************************************************
    // Channel output codes
    // ********************************************************
    localparam logic [1:0] CODE_HIZ = 2'h0;
    localparam logic [1:0] CODE_NEG = 2'h1;
    localparam logic [1:0] CODE_POS = 2'h2;
    localparam logic [1:0] CODE_GND = 2'h3;

    // ********************************************************
    // Array indices
    // ********************************************************
    localparam logic [1:0] ARR_A = 2'h0;
    localparam logic [1:0] ARR_B = 2'h1;
    localparam logic [1:0] ARR_C = 2'h2;
    localparam logic [1:0] ARR_D = 2'h3;

    // ********************************************************
    // Positions of the pins in the synchroniser vector
    // ********************************************************
    localparam int IN_SCK = 0;
    localparam int IN_SS = 1;
    localparam int IN_SDI = 2;
    localparam int IN_LD = 3;
    localparam int IN_SA = 4;
    localparam int IN_SB = 5;
    localparam int IN_SC = 6;
    localparam int IN_SD = 7;
    localparam int IN_PD = 8;
    localparam int IN_W = 9;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [SR_W-1:0] SR_RST = 128'h0;
    localparam logic [CTRL_W-1:0] ARR_RST = 32'h0;
    localparam logic [CTRL_W-1:0] CTRL_RST = 32'h0;
    localparam logic [IN_W-1:0] SYNC_RST = 9'h0;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_NS = 20;
    localparam int BREAK_NS = 100;
    localparam int BREAK_CYCLES = (BREAK_NS + CLK_NS - 1) / CLK_NS;
    localparam int BRK_CNT_W = 4;
    localparam int PD_RESPONSE_US = 1000;
    localparam int PD_MAX_CYCLES = (PD_RESPONSE_US * 1000) / CLK_NS;

endpackage

// ---- verification/qlos_host.sv ----
// Host model driving the serial port, the strobe pins and the shutdown pin
module qlos_host (
    input wire logic clk, // System clock
    input wire logic sdo, // Serial data back from the block
    output logic sck, // Serial clock, low outside frames
    output logic ss_n, // Serial select
    output logic sdi, // Serial data
    output logic ld_n, // Array load strobe
    output logic sa_n, // Select array A
    output logic sb_n, // Select array B
    output logic sc_n, // Select array C
    output logic sd_n, // Select array D
    output logic pd // Shutdown request
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {sck, ss_n, sdi, ld_n, sa_n, sb_n, sc_n, sd_n, pd} = 9'h0;
    end
    // Every pin change lands a fixed 2 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // Idle levels once supplies are up
    task automatic wake();
        {ss_n, ld_n, sa_n, sb_n, sc_n, sd_n} = 6'h3f;
    endtask
    task automatic off();
        {sck, ss_n, sdi, ld_n, sa_n, sb_n, sc_n, sd_n, pd} = 9'h0;
    endtask
    // Sends d, top bit first, at 160 ns per bit; returns what sdo showed
    task automatic shift(input logic [127:0] d, output logic [127:0] got);
        ss_n = 1'b0;
        for (int i = 127; i >= 0; i--) begin
            sdi = d[i];
            tick(4);
            got[i] = sdo;
            sck = 1'b1;
            tick(4);
            sck = 1'b0;
        end
        tick(4);
        ss_n = 1'b1;
        // Line no longer selected, so it must not keep showing the last bit
        sdi = ~sdi;
        // Keep the select high long enough that back-to-back frames see a fresh fall
        tick(4);
    endtask
    // Bits of m: load, A, B, C, D; the long gap lets a load or a break finish
    task automatic strobe(input logic [4:0] m);
        {ld_n, sa_n, sb_n, sc_n, sd_n} = ~m;
        tick(3);
        {ld_n, sa_n, sb_n, sc_n, sd_n} = 5'h1f;
        tick(12);
    endtask
    task automatic power(input logic v);
        pd = v;
        tick(1);
    endtask
endmodule

// ---- verification/quad_latch_output_select_bench.sv ----
// Self-checking bench for the quad latch output select block
`define CHK(what, exp, seen) \
    begin \
        samples_checked++; \
        if ((seen) !== (exp)) begin \
            error_cnt++; \
            $display("unexpected %s expected %h seen %h", what, exp, seen); \
        end \
    end
module quad_latch_output_select_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BRK = 5;
    localparam logic [127:0] PAT = 128'h5aa53cc3_9c630ff0_1b1b1b1b_e4e4e4e4;
    logic clk, resetn, sck, ss_n, sdi, ld_n, sa_n, sb_n, sc_n, sd_n, pd, sdo, powered_down;
    logic [qlos_pkg::CTRL_W-1:0] hv;
    logic [qlos_pkg::NUM_CH-1:0] pos, neg, gnd;
    logic [qlos_pkg::SR_W-1:0] got;
    int error_cnt = 0;
    int samples_checked = 0;
    qlos_core #(.BREAK_CYCLES(BRK), .PD_MAX_CYCLES(50)) dut (.clk(clk), .resetn(resetn),
        .sck(sck), .ss_n(ss_n), .sdi(sdi), .array_load_strobe_n(ld_n), .select_array_a_n(sa_n),
        .select_array_b_n(sb_n), .select_array_c_n(sc_n), .select_array_d_n(sd_n),
        .power_down_pin(pd), .sdo(sdo), .high_voltage_output(hv), .hv_pull_pos(pos),
        .hv_pull_neg(neg), .hv_to_gnd(gnd), .powered_down(powered_down));
    qlos_host host (.clk(clk), .sdo(sdo), .sck(sck), .ss_n(ss_n), .sdi(sdi), .ld_n(ld_n),
        .sa_n(sa_n), .sb_n(sb_n), .sc_n(sc_n), .sd_n(sd_n), .pd(pd));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Expected {positive, negative, ground} lines for a control word
    function automatic logic [47:0] dec(input logic [31:0] v);
        for (int c = 0; c < 16; c++) begin
            dec[32 + c] = v[2*c +: 2] == qlos_pkg::CODE_POS;
            dec[16 + c] = v[2*c +: 2] == qlos_pkg::CODE_NEG;
            dec[c] = v[2*c +: 2] == qlos_pkg::CODE_GND;
        end
    endfunction
    task automatic check_out(input string what, input logic [31:0] v);
        `CHK(what, v, hv)
        `CHK("decode", dec(v), {pos, neg, gnd})
    endtask
    task automatic t_reset();
        resetn = 1'b0;
        host.tick(2);
        `CHK("outputs in reset", 32'h0, hv)
        resetn = 1'b1;
        host.tick(2);
        host.wake();
        host.tick(4);
        host.strobe(5'h01);
        check_out("array D after reset", 32'h0);
        host.shift(~PAT, got);
        `CHK("buffer after reset", 128'h0, got)
    endtask
    task automatic t_load();
        host.shift(PAT, got);
        `CHK("chained out", ~PAT, got)
        host.tick(40);
        host.strobe(5'h10);
        for (int k = 0; k < 4; k++) begin
            host.strobe(5'h08 >> k);
            check_out("selected array", PAT[32*k +: 32]);
        end
    endtask
    task automatic t_break();
        int zeros;
        zeros = 0;
        fork
            host.strobe(5'h08);
            repeat (20) begin
                host.tick(1);
                zeros += (hv === 32'h0);
            end
        join
        `CHK("break cycles", BRK, zeros)
        check_out("array A", PAT[31:0]);
        host.strobe(5'h03);
        check_out("C over D", PAT[95:64]);
        host.strobe(5'h06);
        check_out("B over C", PAT[63:32]);
        host.strobe(5'h0f);
        check_out("A over all", PAT[31:0]);
    endtask
    task automatic t_indep();
        host.shift(~PAT, got);
        `CHK("chained out", PAT, got)
        check_out("outputs after shift", PAT[31:0]);
        host.strobe(5'h04);
        check_out("array B kept", PAT[63:32]);
        host.strobe(5'h10);
        host.strobe(5'h04);
        check_out("array B reloaded", ~PAT[63:32]);
    endtask
    task automatic wait_down(input logic v);
        for (int i = 0; i < 50 && powered_down !== v; i++) host.tick(1);
        `CHK("shutdown state", v, powered_down)
    endtask
    task automatic t_shutdown();
        host.power(1'b1);
        wait_down(1'b1);
        `CHK("shutdown outputs", 32'h0, hv)
        `CHK("shutdown serial out", 1'b0, sdo)
        host.strobe(5'h02);
        host.power(1'b0);
        wait_down(1'b0);
        check_out("restored", ~PAT[63:32]);
    endtask
    task automatic end_of_test();
        host.off();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        resetn = 1'b0;
        t_reset();
        t_load();
        t_break();
        t_indep();
        t_shutdown();
        t_reset();
        end_of_test();
    end
    // Four frames of about 21 us each plus strobes stay well under this
    initial begin
        #500us;
        error_cnt++;
        end_of_test();
    end
endmodule

// ---- verilog/qlos_core.sv ----
// Quad latch output select: serial buffer, four pattern arrays, output control
module qlos_core #(
    parameter int BREAK_CYCLES = qlos_pkg::BREAK_CYCLES,
    parameter int PD_MAX_CYCLES = qlos_pkg::PD_MAX_CYCLES
) (
    input wire logic clk, // System clock, 50 MHz
    input wire logic resetn, // Power-on reset, active low
    input wire logic sck, // Serial clock from host
    input wire logic ss_n, // Serial select, active low
    input wire logic sdi, // Serial data in
    input wire logic array_load_strobe_n, // Buffer to arrays, falling edge
    input wire logic select_array_a_n, // Array A to output, falling edge
    input wire logic select_array_b_n, // Array B to output, falling edge
    input wire logic select_array_c_n, // Array C to output, falling edge
    input wire logic select_array_d_n, // Array D to output, falling edge
    input wire logic power_down_pin, // Shutdown request, active high
    output logic sdo, // Serial data out to next device
    output logic [qlos_pkg::CTRL_W-1:0] high_voltage_output, // Channel codes on the pins
    output logic [qlos_pkg::NUM_CH-1:0] hv_pull_pos, // Channel pulled to positive rail
    output logic [qlos_pkg::NUM_CH-1:0] hv_pull_neg, // Channel pulled to negative rail
    output logic [qlos_pkg::NUM_CH-1:0] hv_to_gnd, // Channel driven to ground
    output logic powered_down // Shutdown state in force
);

    // ********************************************************
    // Parameter checks
    // ********************************************************
    if (BREAK_CYCLES < 1 || BREAK_CYCLES > 15) begin : g_bad_break
        $error("BREAK_CYCLES must lie in 1..15");
    end
    if (PD_MAX_CYCLES < 3) begin : g_bad_pd
        $error("PD_MAX_CYCLES must be at least 3");
    end

    localparam logic [qlos_pkg::BRK_CNT_W-1:0] BRK_LOAD = qlos_pkg::BRK_CNT_W'(BREAK_CYCLES);

    // ********************************************************
    // State
    // ********************************************************
    typedef enum logic {SEL_IDLE, SEL_BREAK} qlos_sel_t;

    typedef struct packed {
        logic [qlos_pkg::IN_W-1:0] meta;
        logic [qlos_pkg::IN_W-1:0] sync;
        logic [qlos_pkg::IN_W-1:0] prev;
        logic [qlos_pkg::SR_W-1:0] sr;
        logic [qlos_pkg::NUM_ARR-1:0][qlos_pkg::CTRL_W-1:0] arr;
        logic [qlos_pkg::CTRL_W-1:0] ctrl;
        qlos_sel_t sel;
        logic [1:0] pend;
        logic [qlos_pkg::BRK_CNT_W-1:0] cnt;
        logic down;
        logic sdo;
        logic [qlos_pkg::CTRL_W-1:0] hv;
        logic [qlos_pkg::NUM_CH-1:0] pos;
        logic [qlos_pkg::NUM_CH-1:0] neg;
        logic [qlos_pkg::NUM_CH-1:0] gnd;
    } qlos_state_t;

    qlos_state_t st_q;
    qlos_state_t st_d;
    logic [qlos_pkg::IN_W-1:0] pins;
    logic [qlos_pkg::IN_W-1:0] rises;
    logic [qlos_pkg::IN_W-1:0] falls;
    logic act;
    logic spi_on;
    logic [3:0] sel_req;
    logic sel_go;

    always_comb begin
        pins = '0;
        pins[qlos_pkg::IN_SCK] = sck;
        pins[qlos_pkg::IN_SS] = ss_n;
        pins[qlos_pkg::IN_SDI] = sdi;
        pins[qlos_pkg::IN_LD] = array_load_strobe_n;
        pins[qlos_pkg::IN_SA] = select_array_a_n;
        pins[qlos_pkg::IN_SB] = select_array_b_n;
        pins[qlos_pkg::IN_SC] = select_array_c_n;
        pins[qlos_pkg::IN_SD] = select_array_d_n;
        pins[qlos_pkg::IN_PD] = power_down_pin;
    end

    assign rises = st_q.sync & ~st_q.prev;
    assign falls = st_q.prev & ~st_q.sync;
    assign act = ~st_q.sync[qlos_pkg::IN_PD];
    assign spi_on = act & ~st_q.sync[qlos_pkg::IN_SS];
    assign sel_req = act ? falls[qlos_pkg::IN_SA +: 4] : 4'h0;
    assign sel_go = (st_q.sel == SEL_IDLE) && (sel_req != 4'h0);

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        st_d = st_q;
        st_d.meta = pins;
        st_d.sync = st_q.meta;
        st_d.prev = st_q.sync;
        // Shutdown follows the synchronised pin one cycle later
        st_d.down = st_q.sync[qlos_pkg::IN_PD];

        // Serial buffer: shift only on a qualified rising edge
        if (spi_on && rises[qlos_pkg::IN_SCK]) begin
            st_d.sr = {st_q.sr[qlos_pkg::SR_W-2:0], st_q.sync[qlos_pkg::IN_SDI]};
        end
        if (!act) begin
            st_d.sdo = 1'b0;
        end else if (falls[qlos_pkg::IN_SS] || (spi_on && falls[qlos_pkg::IN_SCK])) begin
            st_d.sdo = st_q.sr[qlos_pkg::SR_W-1];
        end

        // Array load from the buffer
        if (act && falls[qlos_pkg::IN_LD]) begin
            for (int i = 0; i < qlos_pkg::NUM_ARR; i++) begin
                st_d.arr[i] = st_q.sr[i*qlos_pkg::CTRL_W +: qlos_pkg::CTRL_W];
            end
        end

        // Output register reload with a break interval
        unique case (st_q.sel)
            SEL_IDLE: begin
                if (sel_go) begin
                    if (sel_req[0]) begin
                        st_d.pend = qlos_pkg::ARR_A;
                    end else if (sel_req[1]) begin
                        st_d.pend = qlos_pkg::ARR_B;
                    end else if (sel_req[2]) begin
                        st_d.pend = qlos_pkg::ARR_C;
                    end else begin
                        st_d.pend = qlos_pkg::ARR_D;
                    end
                    st_d.sel = SEL_BREAK;
                    st_d.cnt = BRK_LOAD;
                end
            end
            SEL_BREAK: begin
                if (st_q.cnt == 4'h1) begin
                    // Array is read at the end of the break, after any load that finished before this cycle
                    st_d.ctrl = st_q.arr[st_q.pend];
                    st_d.sel = SEL_IDLE;
                end else begin
                    st_d.cnt = st_q.cnt - 4'h1;
                end
            end
        endcase

        // Pins are undriven during shutdown and during a reload
        if (st_d.down || st_d.sel == SEL_BREAK) begin
            st_d.hv = qlos_pkg::CTRL_RST;
        end else begin
            st_d.hv = st_d.ctrl;
        end
        for (int c = 0; c < qlos_pkg::NUM_CH; c++) begin
            st_d.pos[c] = st_d.hv[2*c +: 2] == qlos_pkg::CODE_POS;
            st_d.neg[c] = st_d.hv[2*c +: 2] == qlos_pkg::CODE_NEG;
            st_d.gnd[c] = st_d.hv[2*c +: 2] == qlos_pkg::CODE_GND;
        end
    end

    // ********************************************************
    // Registers
    // ********************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q.meta <= qlos_pkg::SYNC_RST;
            st_q.sync <= qlos_pkg::SYNC_RST;
            st_q.prev <= qlos_pkg::SYNC_RST;
            st_q.sr <= qlos_pkg::SR_RST;
            st_q.arr <= {qlos_pkg::NUM_ARR{qlos_pkg::ARR_RST}};
            st_q.ctrl <= qlos_pkg::CTRL_RST;
            st_q.sel <= SEL_IDLE;
            st_q.pend <= qlos_pkg::ARR_A;
            st_q.cnt <= 4'h0;
            st_q.down <= 1'b0;
            st_q.sdo <= 1'b0;
            st_q.hv <= qlos_pkg::CTRL_RST;
            st_q.pos <= 16'h0;
            st_q.neg <= 16'h0;
            st_q.gnd <= 16'h0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sdo = st_q.sdo;
    assign high_voltage_output = st_q.hv;
    assign hv_pull_pos = st_q.pos;
    assign hv_pull_neg = st_q.neg;
    assign hv_to_gnd = st_q.gnd;
    assign powered_down = st_q.down;

    // ********************************************************
    // Assertions
    // ********************************************************
    localparam int BRK_M1 = BREAK_CYCLES - 1;
    localparam int BRK_P1 = BREAK_CYCLES + 1;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    chk_code_decode: assert property (
        hv_pull_pos[3] == (high_voltage_output[7:6] == 2'h2) &&
        hv_pull_neg[3] == (high_voltage_output[7:6] == 2'h1) &&
        hv_to_gnd[15] == (high_voltage_output[31:30] == 2'h3))
        else $error("channel decode does not match code");
    chk_ctrl_change: assert property (
        !$stable(st_q.ctrl) |-> $past(st_q.sel == SEL_BREAK && st_q.cnt == 4'h1))
        else $error("output control changed outside a reload");
    chk_select_copy: assert property (
        (sel_go && sel_req[1] && !sel_req[0]) |-> ##BRK_P1
        (st_q.ctrl == $past(st_q.arr[1]) && high_voltage_output == st_q.ctrl))
        else $error("array B not copied after break");
    chk_break_hiz: assert property (
        sel_go |=> (high_voltage_output == 32'h0) ##BRK_M1 (high_voltage_output == 32'h0))
        else $error("outputs driven during reload");
    chk_buffer_hold: assert property (
        !(spi_on && rises[qlos_pkg::IN_SCK]) |=> $stable(st_q.sr))
        else $error("buffer changed without a shift");
    chk_load_slices: assert property (
        (act && falls[qlos_pkg::IN_LD]) |=>
        (st_q.arr[3] == $past(st_q.sr[127:96]) && st_q.arr[0] == $past(st_q.sr[31:0])))
        else $error("array load slices wrong");
    chk_sdo_fall: assert property (
        (spi_on && falls[qlos_pkg::IN_SCK]) |=> sdo == $past(st_q.sr[127]))
        else $error("serial out not the buffer top bit");
    chk_arr_indep: assert property (
        !(act && falls[qlos_pkg::IN_LD]) |=> $stable(st_q.arr))
        else $error("arrays changed without load strobe");
    chk_pd_quiet: assert property (
        powered_down |-> (high_voltage_output == 32'h0 && !sdo))
        else $error("outputs active in shutdown");
    chk_pd_follow: assert property (
        $rose(st_q.sync[qlos_pkg::IN_PD]) |-> ##[1:2] powered_down)
        else $error("shutdown entry too slow");
    chk_shift_msb: assert property (
        (spi_on && rises[qlos_pkg::IN_SCK]) |=>
        (st_q.sr[0] == $past(st_q.sync[qlos_pkg::IN_SDI]) && st_q.sr[127:1] == $past(st_q.sr[126:0])))
        else $error("shift order wrong");
    chk_sel_prio: assert property (
        (sel_go && sel_req[0] && sel_req[3]) |=> st_q.pend == qlos_pkg::ARR_A)
        else $error("select priority wrong");
    chk_reset_hiz: assert property (
        $rose(resetn) |-> (high_voltage_output == 32'h0 && st_q.arr == '0))
        else $error("reset left outputs or arrays set");

    cov_select: cover property (sel_go ##BRK_P1 high_voltage_output != 32'h0);
    cov_load: cover property (act && falls[qlos_pkg::IN_LD]);
    cov_shift: cover property (spi_on && rises[qlos_pkg::IN_SCK]);
    cov_power_down: cover property ($rose(powered_down));

endmodule
